// ---- src/gpio_reset_strap_logic.sv ----
`timescale 1ns/1ns
module gpio_reset_strap_logic
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // reset pins
    input  wire logic       hw_reset_in,
    input  wire logic       manual_reset_in,
    input  wire logic       mrst_low_active,
    input  wire logic       switched_3v3_rail,
    output logic            sys_reset_out_n,
    output logic            sys_reset_out_oe,
    // strap pins
    input  wire logic       addr_strap_b4,
    input  wire logic       addr_strap_b5,
    input  wire logic       bus_power_strap,
    output logic [6:0]      i2c_addr_bits,
    output logic            power_paths_block,
    // flash reload
    output logic            flash_reload_req,
    input  wire logic       flash_reload_done,
    output logic            config_ready,
    // superspeed mux
    input  wire logic       mux_enable_sel,
    input  wire logic       mux_enable_val,
    input  wire logic       mux_polarity_sel,
    input  wire logic       mux_polarity_val,
    input  wire logic       mux_altmode_sel_en,
    input  wire logic       mux_altmode_val,
    input  wire logic       mux_altmode_drive,
    input  wire logic       dead_battery,
    output logic            ss_mux_enable,
    output logic            ss_mux_enable_oe,
    output logic            ss_mux_polarity,
    output logic            ss_mux_polarity_oe,
    output logic            ss_mux_altmode_sel,
    output logic            ss_mux_altmode_sel_oe,
    // hot plug detect
    input  wire logic       dp_supported,
    input  wire logic [1:0] hpd4_mode,
    input  wire logic       hpd5_rx_en,
    input  wire logic       hpd_tx_val,
    input  wire logic       gpio4_in,
    input  wire logic       gpio5_in,
    output logic            gpio4_out,
    output logic            gpio4_oe,
    output logic            hpd_rx
);
    import gpio_strap_pkg::*;

    strap_if sl ();

    boot_state_t      state_reg;
    boot_state_t      state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             mrst_act;
    logic             rst_out_n_reg;
    logic             rst_out_n_next;
    logic             out_reg;
    logic [5:0]       mux_next;
    logic [5:0]       mux_reg;
    logic [2:0]       hpd_next;
    logic [2:0]       hpd_reg;

    localparam logic [CNT_W-1:0] LOAD_LAST = CNT_W'(FLASH_LOAD_CYC - 1);

    strap_latch i_strap_latch
    (
        .clk             (clk),
        .rst             (rst),
        .addr_strap_b4   (addr_strap_b4),
        .addr_strap_b5   (addr_strap_b5),
        .bus_power_strap (bus_power_strap),
        .sl              (sl.latch)
    );

    // boot: sample straps, reload from flash, run
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sl.sample  = 1'b0;
        case (state_reg)
            ST_SAMPLE:
            begin
                sl.sample  = 1'b1;
                cnt_next   = '0;
                state_next = ST_LOAD;
            end
            ST_LOAD:
            begin
                if (cnt_reg != LOAD_LAST)
                begin
                    cnt_next = cnt_reg + 1'b1;
                end
                else if (flash_reload_done)
                begin
                    state_next = ST_RUN;
                end
            end
            default:
            begin
                state_next = ST_RUN;
            end
        endcase
        if (hw_reset_in)
        begin
            state_next = ST_SAMPLE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ST_SAMPLE;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign flash_reload_req = (state_reg == ST_LOAD);
    assign config_ready     = (state_reg == ST_RUN);

    // reset output
    always_comb
    begin
        mrst_act = mrst_low_active ? !manual_reset_in
                                   : manual_reset_in;
        rst_out_n_next = switched_3v3_rail
                         && !mrst_act && !hw_reset_in
                         && (state_reg == ST_RUN);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rst_out_n_reg <= 1'b0;
            out_reg       <= 1'b0;
        end
        else
        begin
            rst_out_n_reg <= rst_out_n_next;
            out_reg       <= 1'b1;
        end
    end

    assign sys_reset_out_n  = rst_out_n_reg;
    assign sys_reset_out_oe = 1'b1;

    // only the strapped bits come from here, the rest stay zero
    always_comb
    begin
        i2c_addr_bits              = '0;
        i2c_addr_bits[ADDR_B4_POS] = sl.b4;
        i2c_addr_bits[ADDR_B5_POS] = sl.b5;
    end
    assign power_paths_block = sl.bus_power && dead_battery;

    // superspeed mux pins: {altmode oe, altmode, pol oe, pol, en oe, en}
    always_comb
    begin
        mux_next = '0;
        if (config_ready)
        begin
            mux_next[0] = mux_enable_sel && mux_enable_val;
            mux_next[1] = mux_enable_sel;
            mux_next[2] = mux_polarity_sel && mux_polarity_val;
            mux_next[3] = mux_polarity_sel;
            mux_next[4] = mux_altmode_sel_en && mux_altmode_val;
            mux_next[5] = mux_altmode_sel_en && mux_altmode_drive;
        end
    end

    // hot plug detect: {gpio4 out, gpio4 oe, rx}
    always_comb
    begin
        hpd_next = '0;
        if (dp_supported && config_ready)
        begin
            if (hpd4_mode == HPD_TX || hpd4_mode == HPD_TXRX)
            begin
                hpd_next[2] = hpd_tx_val;
                hpd_next[1] = 1'b1;
            end
            if (hpd4_mode == HPD_RX || hpd4_mode == HPD_TXRX)
            begin
                hpd_next[0] = gpio4_in;
            end
            else if (hpd5_rx_en)
            begin
                hpd_next[0] = gpio5_in;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mux_reg <= '0;
            hpd_reg <= '0;
        end
        else
        begin
            mux_reg <= mux_next;
            hpd_reg <= hpd_next;
        end
    end

    assign ss_mux_enable         = mux_reg[0];
    assign ss_mux_enable_oe      = mux_reg[1];
    assign ss_mux_polarity       = mux_reg[2];
    assign ss_mux_polarity_oe    = mux_reg[3];
    assign ss_mux_altmode_sel    = mux_reg[4];
    assign ss_mux_altmode_sel_oe = mux_reg[5];
    assign gpio4_out             = hpd_reg[2];
    assign gpio4_oe              = hpd_reg[1];
    assign hpd_rx                = hpd_reg[0];

    a_rail_low_rst: assert property (@(posedge clk) disable iff (rst)
        !switched_3v3_rail |=> !sys_reset_out_n)
        else $error("reset output released with rail low");
    a_start_low: assert property (@(posedge clk)
        $rose(out_reg) |-> !sys_reset_out_n && sys_reset_out_oe)
        else $error("reset output not low at start-up");
    a_mrst_high: assert property (@(posedge clk) disable iff (rst)
        (!mrst_low_active && manual_reset_in) |=> !sys_reset_out_n)
        else $error("manual reset high did not assert reset");
    a_mrst_low: assert property (@(posedge clk) disable iff (rst)
        (mrst_low_active && !manual_reset_in) |=> !sys_reset_out_n)
        else $error("manual reset low did not assert reset");
    a_hw_reload: assert property (@(posedge clk) disable iff (rst)
        hw_reset_in ##1 !hw_reset_in |-> ##1 flash_reload_req)
        else $error("hardware reset did not start reload");
    a_hw_hold: assert property (@(posedge clk) disable iff (rst)
        hw_reset_in |=> !config_ready)
        else $error("hardware reset did not stop operation");
    a_hpd_tx: assert property (@(posedge clk) disable iff (rst)
        (dp_supported && config_ready && hpd4_mode == HPD_TX)
        |=> gpio4_oe && gpio4_out == $past(hpd_tx_val))
        else $error("hot plug transmit not driven");
    a_mux_pol: assert property (@(posedge clk) disable iff (rst)
        (config_ready && mux_polarity_sel)
        |=> ss_mux_polarity == $past(mux_polarity_val))
        else $error("mux polarity not driven");
endmodule : gpio_reset_strap_logic

// ---- src/gpio_strap_pkg.sv ----
// Summary of operation
// - reset output low while switched rail low
// - reset output driven low at start-up
// - manual reset input forces reset, default high
// - manual reset polarity selectable, low asserts
// - first debug strap sampled as address bit 4
// - second debug strap sampled as address bit 5
// - hardware reset input is active high
// - hardware reset reloads settings from flash
// - pin 4 hot plug transmit, receive or both
// - pin 5 optional hot plug receive input
// - pin 3 drives mux enable output
// - pin 14 drives mux polarity output
// - bus power strap sampled at each boot, disables paths on dead battery
// - pin 0 mux altmode select, tri-state capable
package gpio_strap_pkg;
    localparam int ADDR_B4_POS = 4;
    localparam int ADDR_B5_POS = 5;
    localparam logic [1:0] HPD_OFF  = 2'h0;
    localparam logic [1:0] HPD_TX   = 2'h1;
    localparam logic [1:0] HPD_RX   = 2'h2;
    localparam logic [1:0] HPD_TXRX = 2'h3;
    localparam logic       MRST_POL_DEFAULT = 1'h1;
    // flash reload time, stands for the boot loader's read-out
    localparam int FLASH_LOAD_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLASH_LOAD_CYC =
        (FLASH_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_LOAD,
        ST_RUN
    } boot_state_t;
endpackage : gpio_strap_pkg

// ---- src/strap_if.sv ----
`timescale 1ns/1ns
interface strap_if;
    import gpio_strap_pkg::*;
    logic sample;
    logic b4;
    logic b5;
    logic bus_power;
    modport ctrl (output sample, input b4, b5, bus_power);
    modport latch (input sample, output b4, b5, bus_power);
endinterface : strap_if

// ---- src/strap_latch.sv ----
`timescale 1ns/1ns
module strap_latch
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // strap pins
    input  wire logic addr_strap_b4,
    input  wire logic addr_strap_b5,
    input  wire logic bus_power_strap,
    // held values
    strap_if.latch    sl
);
    import gpio_strap_pkg::*;
    logic [2:0] val_reg;
    logic [2:0] val_next;

    always_comb
    begin
        val_next = val_reg;
        if (sl.sample)
        begin
            val_next = {bus_power_strap, addr_strap_b5, addr_strap_b4};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            val_reg <= 3'h0;
        end
        else
        begin
            val_reg <= val_next;
        end
    end

    assign sl.b4        = val_reg[0];
    assign sl.b5        = val_reg[1];
    assign sl.bus_power = val_reg[2];

    a_strap_hold: assert property (@(posedge clk) disable iff (rst)
        !sl.sample |=> $stable(val_reg))
        else $error("strap value moved without sampling");
    a_strap_take: assert property (@(posedge clk) disable iff (rst)
        sl.sample |=> val_reg[0] == $past(addr_strap_b4))
        else $error("address bit 4 not sampled");
    a_strap_b5: assert property (@(posedge clk) disable iff (rst)
        sl.sample |=> val_reg[1] == $past(addr_strap_b5))
        else $error("address bit 5 not sampled");
    a_strap_bp: assert property (@(posedge clk) disable iff (rst)
        sl.sample |=> val_reg[2] == $past(bus_power_strap))
        else $error("bus power strap not sampled");
endmodule : strap_latch

// ---- sim/flash_loader_model.sv ----
`timescale 1ns/1ns
module flash_loader_model
(
    // clock
    input  wire logic clk,
    // loader handshake
    input  wire logic slow,
    input  wire logic flash_reload_req,
    output logic      flash_reload_done
);
    int cnt = 0;
    initial flash_reload_done = 1'b0;
    // done held while requested, dropped once the request goes away
    always @(posedge clk)
    begin
        if (!flash_reload_req)
        begin
            cnt <= 0;
            flash_reload_done <= 1'b0;
        end
        else if (cnt >= (slow ? 150 : 20))
            flash_reload_done <= 1'b1;
        else
            cnt <= cnt + 1;
    end
endmodule : flash_loader_model

// ---- sim/tb_gpio_reset_strap_logic.sv ----
`timescale 1ns/1ns
module tb_gpio_reset_strap_logic;
    import gpio_strap_pkg::*;
    logic clk, rst, hw_reset_in, manual_reset_in, mrst_low_active, slow;
    logic switched_3v3_rail, sys_reset_out_n, sys_reset_out_oe;
    logic addr_strap_b4, addr_strap_b5, bus_power_strap, power_paths_block;
    logic [6:0] i2c_addr_bits;
    logic flash_reload_req, flash_reload_done, config_ready, dead_battery;
    logic mux_enable_sel, mux_enable_val, mux_polarity_sel, mux_polarity_val;
    logic mux_altmode_sel_en, mux_altmode_val, mux_altmode_drive;
    logic ss_mux_enable, ss_mux_enable_oe, ss_mux_polarity, ss_mux_polarity_oe;
    logic ss_mux_altmode_sel, ss_mux_altmode_sel_oe, dp_supported, hpd5_rx_en;
    logic [1:0] hpd4_mode;
    logic hpd_tx_val, gpio4_in, gpio5_in, gpio4_out, gpio4_oe, hpd_rx;
    int n_errors = 0;
    int total_checks = 0;
    int exp_addr, exp_bp, seed;

    gpio_reset_strap_logic i_gpio_reset_strap_logic
    (
        .clk, .rst, .hw_reset_in, .manual_reset_in, .mrst_low_active,
        .switched_3v3_rail, .sys_reset_out_n, .sys_reset_out_oe,
        .addr_strap_b4, .addr_strap_b5, .bus_power_strap, .i2c_addr_bits,
        .power_paths_block, .flash_reload_req, .flash_reload_done,
        .config_ready, .mux_enable_sel, .mux_enable_val, .mux_polarity_sel,
        .mux_polarity_val, .mux_altmode_sel_en, .mux_altmode_val,
        .mux_altmode_drive, .dead_battery, .ss_mux_enable, .ss_mux_enable_oe,
        .ss_mux_polarity, .ss_mux_polarity_oe, .ss_mux_altmode_sel,
        .ss_mux_altmode_sel_oe, .dp_supported, .hpd4_mode, .hpd5_rx_en,
        .hpd_tx_val, .gpio4_in, .gpio5_in, .gpio4_out, .gpio4_oe, .hpd_rx
    );

    flash_loader_model i_flash_loader_model
    (
        .clk, .slow, .flash_reload_req, .flash_reload_done
    );

    always #5 clk = ~clk;

    task step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task test_done;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // straps taken at the next edge, then a full reload
    task boot;
        int cnt;
        exp_addr = (int'(addr_strap_b5) << 5) | (int'(addr_strap_b4) << 4);
        exp_bp = int'(bus_power_strap);
        step(1);
        {addr_strap_b4, addr_strap_b5, bus_power_strap} =
            ~{addr_strap_b4, addr_strap_b5, bus_power_strap};
        step(1);
        chk("reload_req", 1, flash_reload_req);
        chk("reset_out_load", 0, sys_reset_out_n);
        chk("reset_out_oe", 1, sys_reset_out_oe);
        cnt = 1;
        while (config_ready !== 1'b1 && cnt < 400)
        begin
            step(1);
            cnt++;
        end
        if (config_ready !== 1'b1)
        begin
            n_errors++;
            test_done;
        end
        // slow loader raises done one edge after its 150th counted edge
        chk("load_time", 1, cnt >= (slow ? 152 : FLASH_LOAD_CYC));
        step(1);
        chk("reset_out_run", 1, sys_reset_out_n);
        chk("addr", exp_addr[7:0], {1'b0, i2c_addr_bits});
    endtask : boot

    initial
    begin
        {clk, hw_reset_in, manual_reset_in, mrst_low_active, slow} = '0;
        {mux_enable_sel, mux_enable_val, mux_polarity_sel} = '0;
        {mux_polarity_val, mux_altmode_sel_en, mux_altmode_val} = '0;
        {mux_altmode_drive, dead_battery, hpd4_mode, hpd_tx_val} = '0;
        {gpio4_in, gpio5_in} = '0;
        {rst, switched_3v3_rail, dp_supported, hpd5_rx_en} = 4'hf;
        seed = $urandom(32'hda59);
        {addr_strap_b4, addr_strap_b5, bus_power_strap} = 3'($urandom);
        step(12);
        rst = 1'b0;
        boot;
        // every rail, manual level and polarity combination
        for (int k = 0; k < 8; k++)
        begin
            {switched_3v3_rail, manual_reset_in, mrst_low_active} = 3'(k);
            step(1);
            chk("out_n", k[2] && k[1] == k[0], sys_reset_out_n);
        end
        dead_battery = 1'b1;
        step(1);
        chk("paths_block", exp_bp[7:0], power_paths_block);
        dead_battery = 1'b0;
        step(1);
        chk("paths_free", 0, power_paths_block);
        {mux_enable_sel, mux_polarity_sel, mux_altmode_sel_en} = 3'h7;
        repeat (8)
        begin
            {mux_enable_val, mux_polarity_val} = 2'($urandom);
            {mux_altmode_val, mux_altmode_drive} = 2'($urandom);
            step(2);
            chk("mux_en", mux_enable_val, ss_mux_enable);
            chk("mux_en_oe", 1, ss_mux_enable_oe);
            chk("mux_pol", mux_polarity_val, ss_mux_polarity);
            chk("mux_pol_oe", 1, ss_mux_polarity_oe);
            chk("amsel_oe", mux_altmode_drive, ss_mux_altmode_sel_oe);
            if (mux_altmode_drive)
                chk("amsel", mux_altmode_val, ss_mux_altmode_sel);
        end
        // each hot plug mode of pin 4, pin 5 receiving otherwise
        for (int m = 0; m < 8; m++)
        begin
            hpd4_mode = 2'(m);
            {hpd_tx_val, gpio4_in, gpio5_in} = 3'($urandom);
            step(2);
            chk("hpd4_oe", hpd4_mode[0], gpio4_oe);
            if (hpd4_mode[0])
                chk("hpd4_tx", hpd_tx_val, gpio4_out);
            chk("rx", hpd4_mode[1] ? gpio4_in : gpio5_in, hpd_rx);
        end
        // alternate functions deselected, pin 5 receive off
        {mux_enable_sel, mux_polarity_sel, mux_altmode_sel_en} = 3'h0;
        {hpd5_rx_en, hpd4_mode, gpio5_in} = 4'h3;
        step(2);
        chk("en_oe_off", 0, ss_mux_enable_oe);
        chk("pol_oe_off", 0, ss_mux_polarity_oe);
        chk("amsel_oe_off", 0, ss_mux_altmode_sel_oe);
        chk("hpd5_off", 0, hpd_rx);
        chk("hpd4_tx_oe", 1, gpio4_oe);
        // no hot plug function without display mode support
        {dp_supported, hpd5_rx_en} = 2'h1;
        step(2);
        chk("hpd4_no_dp", 0, gpio4_oe);
        chk("rx_no_dp", 0, hpd_rx);
        hw_reset_in = 1'b1;
        {addr_strap_b4, addr_strap_b5, bus_power_strap} = 3'($urandom);
        step(2);
        chk("hw_reset_out", 0, sys_reset_out_n);
        chk("hw_not_ready", 0, config_ready);
        hw_reset_in = 1'b0;
        slow = 1'b1;
        boot;
        test_done;
    end
endmodule : tb_gpio_reset_strap_logic
